//--- rtl/shift_consts.vh
// constants and mode encodings for the four-stage universal shift register
//
// Overview of operation
// - stages change only on rising clock edge
// - four stages, each shown on its output
// - two selects pick one of four operations
// - both selects low: parallel load all stages
// - A low B high: shift toward stage 0
// - A high B low: shift toward stage 3
// - both selects high: hold all stages
// - outputs follow inputs present at the edge
`ifndef SHIFT_CONSTS_VH
`define SHIFT_CONSTS_VH

// ----------------------------------------
// mode select codes, {mode_select_a, mode_select_b}
// ----------------------------------------
`define MODE_LOAD 2'h0
`define MODE_SHIFT_DOWN 2'h1
`define MODE_SHIFT_UP 2'h2
`define MODE_HOLD 2'h3

// ----------------------------------------
// register geometry
// ----------------------------------------
`define STAGE_COUNT 4
`define BUF_DEPTH 2'h2
`define BUF_ONE 2'h1
`define BUF_EMPTY 2'h0

`endif

//--- rtl/universal_shift_register.v
// four-stage universal shift register with a two-entry result buffer
`timescale 1ns/1ps
`include "shift_consts.vh"

module universal_shift_register (
  input wire clock,
  input wire rst,
  input wire mode_select_a,
  input wire mode_select_b,
  input wire parallel_in_0,
  input wire parallel_in_1,
  input wire parallel_in_2,
  input wire parallel_in_3,
  input wire left_serial_in,
  input wire right_serial_in,
  input wire in_valid,
  output wire in_ready,
  output wire stage_out_0,
  output wire stage_out_1,
  output wire stage_out_2,
  output wire stage_out_3,
  output wire out_valid,
  input wire out_ready,
  output wire [3:0] out_word
);

  // ----------------------------------------
  // stage register
  // ----------------------------------------
  reg [3:0] stage_r;
  reg [3:0] stage_nxt;
  wire [1:0] mode;
  wire accept;
  wire pop;

  assign mode = {mode_select_a, mode_select_b};
  assign accept = in_valid & in_ready;

  always @*
  begin
    stage_nxt = stage_r;
    case (mode)
      `MODE_LOAD:
      begin
        stage_nxt = {parallel_in_3, parallel_in_2, parallel_in_1, parallel_in_0};
      end
      `MODE_SHIFT_DOWN:
      begin
        stage_nxt = {right_serial_in, stage_r[3:1]};
      end
      `MODE_SHIFT_UP:
      begin
        stage_nxt = {stage_r[2:0], left_serial_in};
      end
      `MODE_HOLD:
      begin
        stage_nxt = stage_r;
      end
      default:
      begin
        stage_nxt = stage_r;
      end
    endcase
  end

  // rising edge only; inputs sampled at the edge
  // no reset on the stages; a refused cycle acts as hold
  always @(posedge clock)
  begin
    if (accept)
    begin
      stage_r <= stage_nxt;
    end
  end

  assign stage_out_0 = stage_r[0];
  assign stage_out_1 = stage_r[1];
  assign stage_out_2 = stage_r[2];
  assign stage_out_3 = stage_r[3];

  // ----------------------------------------
  // two-entry result buffer
  // ----------------------------------------
  reg [1:0] count_r;
  reg [3:0] head_r;
  reg [3:0] tail_r;

  // full buffer refuses the next operation so no result is lost
  assign in_ready = (count_r != `BUF_DEPTH);
  assign out_valid = (count_r != `BUF_EMPTY);
  assign out_word = head_r;
  assign pop = out_valid & out_ready;

  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      count_r <= `BUF_EMPTY;
    end
    else if (accept & ~pop)
    begin
      count_r <= count_r + `BUF_ONE;
    end
    else if (pop & ~accept)
    begin
      count_r <= count_r - `BUF_ONE;
    end
  end

  // data slots carry no reset; occupancy alone marks them valid
  always @(posedge clock)
  begin
    if (accept & pop)
    begin
      head_r <= stage_nxt;
    end
    else if (accept)
    begin
      if (count_r == `BUF_EMPTY)
      begin
        head_r <= stage_nxt;
      end
      else
      begin
        tail_r <= stage_nxt;
      end
    end
    else if (pop)
    begin
      head_r <= tail_r;
    end
  end

endmodule

//--- sim/test_universal_shift_register.sv
// self-checking bench for the shift register
`timescale 1ns/1ps
module test_universal_shift_register;
  logic clock=0,rst=1,iv=0,st=1;
  logic [1:0] m=2'h0;
  logic [3:0] d=4'h0,e;
  logic [3:0] w[$];
  wire ir,ov,ordy;
  wire [3:0] q,ow;
  int bad_count=0,checked=0;
  always #4 clock=~clock;
  universal_shift_register universal_shift_register_i(.clock(clock),.rst(rst),.mode_select_a(m[1]),
    .mode_select_b(m[0]),.parallel_in_0(d[0]),.parallel_in_1(d[1]),.parallel_in_2(d[2]),.parallel_in_3(d[3]),
    .left_serial_in(d[1]),.right_serial_in(d[2]),.in_valid(iv),.in_ready(ir),.stage_out_0(q[0]),
    .stage_out_1(q[1]),.stage_out_2(q[2]),.stage_out_3(q[3]),.out_valid(ov),.out_ready(ordy),.out_word(ow));
  usr_sink usr_sink_i(.clock(clock),.stall(st),.out_ready(ordy));
  task chk(input logic [3:0] g,x);
    checked++;
    if(g!==x)
    begin
      bad_count++;
      $display("unexpected %0t got %h",$time,g);
    end
  endtask
  task op(input logic [1:0] k,input logic [3:0] v);
    m=k;
    d=v;
    iv=1;
    while(ir!==1'b1) @(posedge clock) #1;
    @(posedge clock);
    e=k==0?v:k==1?{v[2],e[3:1]}:k==2?{e[2:0],v[1]}:e;
    w.push_back(e);
    #1 chk(q,e);
  endtask
  always @(negedge clock) if(ov===1'b1&&ordy===1'b1) chk(ow,w.pop_front());
  task t_modes;
    st=0;
    for(int i=0;i<8;i++) op(i[1:0],4'hA^i[3:0]);
  endtask
  task t_stall;
    st=1;
    op(2'h0,4'h5);
    op(2'h1,4'h6);
    chk({3'h0,ir},4'h0);
    m=2'h0;
    d=4'hF;
    repeat(3) @(posedge clock);
    #1 chk(q,e);
    iv=0;
    st=0;
    repeat(4) @(posedge clock);
    #1 chk({3'h0,ov},4'h0);
  endtask
  task give_verdict;
    $display("%0d bad of %0d",bad_count,checked);
    if(bad_count==0&&checked>0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat(16) @(posedge clock);
    #1 rst=0;
    t_modes;
    t_stall;
    give_verdict;
  end
  initial
  begin
    #4000;
    bad_count++;
    give_verdict;
  end
endmodule

//--- sim/usr_props_properties.sv
// assertions on the shift register ports
`timescale 1ns/1ps
module usr_props(input wire clock,rst,mode_select_a,mode_select_b,parallel_in_0,parallel_in_1,parallel_in_2,
  parallel_in_3,left_serial_in,right_serial_in,in_valid,in_ready,stage_out_0,stage_out_1,stage_out_2,
  stage_out_3,out_valid,out_ready,input wire [3:0] out_word);
  wire [1:0] m={mode_select_a,mode_select_b};
  wire [3:0] q={stage_out_3,stage_out_2,stage_out_1,stage_out_0};
  wire [3:0] d={parallel_in_3,parallel_in_2,parallel_in_1,parallel_in_0};
  wire ac=in_valid&&in_ready;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_load_all: assert property(ac&&m==0|=>q==$past(d)) else $error("load");
  a_shift_down: assert property(ac&&m==1|=>q=={$past(right_serial_in),$past(q[3:1])}) else $error("down");
  a_shift_up: assert property(ac&&m==2|=>q=={$past(q[2:0]),$past(left_serial_in)}) else $error("up");
  a_hold_still: assert property(in_valid&&(!in_ready||m==3)|=>$stable(q)) else $error("hold");
  a_push_word: assert property(ac|=>out_valid) else $error("push");
  a_word_stands: assert property(out_valid&&!out_ready|=>out_valid&&$stable(out_word)) else $error("word");
  c_down: cover property(ac&&m==1);
  c_up: cover property(ac&&m==2);
  c_full: cover property(in_valid&&!in_ready);
endmodule
bind universal_shift_register usr_props usr_props_i(.*);

//--- sim/usr_sink.sv
// consumer of result words that stalls on request
`timescale 1ns/1ps
module usr_sink(input wire clock,input wire stall,output logic out_ready=1'b0);
  always @(posedge clock) out_ready <= #1 !stall;
endmodule
